// ---- rtl/irs_defines.svh ----
/*
 Constants of the raw event status block: register addresses, field positions,
 widths and reset values.
 Assumes it is included by bare name from the package and every design file.
*/
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH

`define IRS_ADDR_W 32
`define IRS_DATA_W 32
`define IRS_STAT_W 16
`define IRS_ABRT_W 16
`define IRS_BYTE_W 8
`define IRS_LVL_W 6
`define IRS_TL_W 5
`define IRS_LOW_W 4
`define IRS_SYNC_N 3

`define IRS_OFS_MASKED 32'h5000_132C
`define IRS_OFS_MASK 32'h5000_1330
`define IRS_OFS_RAW 32'h5000_1334
`define IRS_OFS_CLR_ALL 32'h5000_1340
`define IRS_OFS_CLR_RDREQ 32'h5000_1350
`define IRS_OFS_CLR_ABRT 32'h5000_1354
`define IRS_OFS_CLR_DONE 32'h5000_1358
`define IRS_OFS_CLR_ACT 32'h5000_135C
`define IRS_OFS_CLR_STOP 32'h5000_1360
`define IRS_OFS_CLR_START 32'h5000_1364
`define IRS_OFS_CLR_GCALL 32'h5000_1368
`define IRS_OFS_ABRT_SRC 32'h5000_1380

`define IRS_B_GCALL 11
`define IRS_B_START 10
`define IRS_B_STOP 9
`define IRS_B_ACT 8
`define IRS_B_DONE 7
`define IRS_B_ABRT 6
`define IRS_B_RDREQ 5
`define IRS_B_TXE 4
`define IRS_CLR_BIT 0

`define IRS_MASK_RST 16'h08FF
`define IRS_CLR_ALL_MASK 16'h0FE0
`define IRS_DIS_MASK 16'h0900

`endif

// ---- rtl/irs_pkg.sv ----
/*
 Types shared by the raw event status block and its link-side front end.
 Assumes irs_defines.svh is on the include path.
*/
`include "irs_defines.svh"

package irs_pkg;

   typedef logic [`IRS_STAT_W-1:0] irs_stat_t;
   typedef logic [`IRS_ABRT_W-1:0] irs_abrt_t;
   typedef logic [`IRS_BYTE_W-1:0] irs_byte_t;

   // Event lanes carried as toggles from the link domain
   typedef enum {EVL_START, EVL_STOP, EVL_GCALL, EVL_NACK, EVL_RDREQ, EVL_COUNT} irs_evt_lane_t;

   // Lanes synchronised into the system clock; the first five follow irs_evt_lane_t
   typedef enum {MS_START, MS_STOP, MS_GCALL, MS_NACK, MS_RDREQ, MS_ABRT, MS_RX, MS_ACT,
      MS_COUNT} irs_msync_t;

   // Lanes synchronised into the link clock
   typedef enum {LS_SCL, LS_SDA, LS_RDDONE, LS_ABACK, LS_RXACK, LS_COUNT} irs_lsync_t;

   typedef enum {RG_NONE, RG_MASKED, RG_MASK, RG_RAW, RG_CLR_ALL, RG_CLR_RDREQ, RG_CLR_ABRT,
      RG_CLR_DONE, RG_CLR_ACT, RG_CLR_STOP, RG_CLR_START, RG_CLR_GCALL,
      RG_ABRT_SRC} irs_reg_t;

endpackage : irs_pkg

// ---- rtl/irs_link_events.sv ----
/*
 Link-side front end: runs on the link clock, watches SCL and SDA for start
 and stop, turns bus state machine events into toggles, hands received bytes
 and abort reasons over by toggle handshakes, and stretches SCL.
 Assumes the bus state machines drive their event inputs on link_clk and that
 link_clk runs while resetn is low.
*/
`timescale 1ns/1ps
`include "irs_defines.svh"

module irs_link_events (
   input wire logic link_clk,
   input wire logic resetn,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic gc_ack_evt,
   input wire logic slv_nack_evt,
   input wire logic abort_evt,
   input wire irs_pkg::irs_abrt_t abort_reason,
   input wire logic rd_req_evt,
   input wire logic rx_byte_valid,
   input wire irs_pkg::irs_byte_t rx_byte,
   output logic rx_byte_ready,
   input wire logic sm_active,
   input wire logic rd_done_tgl,
   input wire logic abrt_ack,
   input wire logic rx_ack,
   output logic [irs_pkg::EVL_COUNT-1:0] ev_tgl,
   output logic abrt_tgl,
   output irs_pkg::irs_abrt_t abrt_word,
   output logic rx_tgl,
   output irs_pkg::irs_byte_t rx_word,
   output logic act_lvl
);
   import irs_pkg::*;

   logic [`IRS_SYNC_N-1:0] rst_sync_q;
   logic link_rstn;
   logic [LS_COUNT-1:0] in_w;
   wire [LS_COUNT-1:0] lf;
   wire [LS_COUNT-1:0] lc;
   logic [EVL_COUNT-1:0] ev_hit;
   logic abrt_busy;
   logic stretch_q;

   ////////////////////////////////////////////////////////////////////////////
   // Reset and input synchronisers

   // Reset is carried over so no link flop leaves reset on a stale system level
   always_ff @(posedge link_clk) begin
      rst_sync_q <= {rst_sync_q[`IRS_SYNC_N-2:0], resetn};
   end
   assign link_rstn = rst_sync_q[`IRS_SYNC_N-1];

   always_comb begin
      in_w = '0;
      in_w[LS_SCL] = scl_i;
      in_w[LS_SDA] = sda_i;
      in_w[LS_RDDONE] = rd_done_tgl;
      in_w[LS_ABACK] = abrt_ack;
      in_w[LS_RXACK] = rx_ack;
   end

   for (genvar gi = 0; gi < LS_COUNT; gi++) begin : g_sync
      // Bus lines idle high, so no false edge is seen when reset lifts
      localparam logic IDLE_V = (gi == LS_SCL) || (gi == LS_SDA);
      logic [`IRS_SYNC_N-1:0] s_q;
      logic f_q;
      always_ff @(posedge link_clk) begin
         if (!link_rstn) begin
            s_q <= {`IRS_SYNC_N{IDLE_V}};
            f_q <= IDLE_V;
         end else begin
            s_q <= {s_q[`IRS_SYNC_N-2:0], in_w[gi]};
            if (s_q[`IRS_SYNC_N-2] == s_q[`IRS_SYNC_N-1]) begin
               f_q <= s_q[`IRS_SYNC_N-1];
            end
         end
      end
      assign lf[gi] = f_q;
      assign lc[gi] = (s_q[`IRS_SYNC_N-2] == s_q[`IRS_SYNC_N-1]) && (s_q[`IRS_SYNC_N-1] != f_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus conditions and events

   always_comb begin
      ev_hit = '0;
      ev_hit[EVL_START] = lc[LS_SDA] & lf[LS_SDA] & lf[LS_SCL];
      ev_hit[EVL_STOP] = lc[LS_SDA] & ~lf[LS_SDA] & lf[LS_SCL];
      ev_hit[EVL_GCALL] = gc_ack_evt;
      ev_hit[EVL_NACK] = slv_nack_evt;
      ev_hit[EVL_RDREQ] = rd_req_evt;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         ev_tgl <= '0;
      end else begin
         ev_tgl <= ev_tgl ^ ev_hit;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         act_lvl <= 1'h0;
      end else begin
         act_lvl <= sm_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word handshakes

   // A second abort while the first reason is in flight keeps the first reason
   assign abrt_busy = abrt_tgl != lf[LS_ABACK];

   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         abrt_tgl <= 1'h0;
         abrt_word <= '0;
      end else if (abort_evt && !abrt_busy) begin
         abrt_word <= abort_reason;
         abrt_tgl <= ~abrt_tgl;
      end
   end

   assign rx_byte_ready = rx_tgl == lf[LS_RXACK];

   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         rx_tgl <= 1'h0;
         rx_word <= '0;
      end else if (rx_byte_valid && rx_byte_ready) begin
         rx_word <= rx_byte;
         rx_tgl <= ~rx_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock stretching

   // Held from the request itself, so SCL is low before the flag even crosses
   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         stretch_q <= 1'h0;
      end else if (rd_req_evt) begin
         stretch_q <= 1'h1;
      end else if (lc[LS_RDDONE]) begin
         stretch_q <= 1'h0;
      end
   end

   assign scl_o = 1'h0;
   assign scl_oe = stretch_q;

endmodule : irs_link_events

// ---- rtl/irs_raw_event_status.sv ----
/*
 Raw event status of the I2C controller: upper status bits, their clear
 registers, the mask and masked status, the abort reason, and the APB slave.
 Assumes the rest of the controller supplies the enable level, the TX FIFO
 level and threshold and the lower status bits, and honours the flush output.
*/
`timescale 1ns/1ps
`include "irs_defines.svh"

module irs_raw_event_status (
   input wire logic clk,
   input wire logic resetn,
   input wire logic link_clk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`IRS_ADDR_W-1:0] paddr,
   input wire logic [`IRS_DATA_W-1:0] pwdata,
   output logic [`IRS_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enable_internal,
   input wire logic [`IRS_LVL_W-1:0] tx_fifo_level,
   input wire logic [`IRS_TL_W-1:0] tx_threshold,
   input wire logic [`IRS_LOW_W-1:0] low_status,
   output logic tx_fifo_flush,
   output logic tx_fifo_accept,
   output logic rx_push,
   output irs_pkg::irs_byte_t rx_data,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic gc_ack_evt,
   input wire logic slv_nack_evt,
   input wire logic abort_evt,
   input wire irs_pkg::irs_abrt_t abort_reason,
   input wire logic rd_req_evt,
   input wire logic rx_byte_valid,
   input wire irs_pkg::irs_byte_t rx_byte,
   output logic rx_byte_ready,
   input wire logic sm_active
);
   import irs_pkg::*;

   logic [EVL_COUNT-1:0] ev_tgl;
   logic abrt_tgl;
   irs_abrt_t abrt_word;
   logic rx_tgl;
   irs_byte_t rx_word;
   logic act_lvl;
   logic [MS_COUNT-1:0] lk_w;
   wire [MS_COUNT-1:0] lf;
   wire [MS_COUNT-1:0] lc;
   logic setup_w;
   logic rd_acc_w;
   irs_reg_t dec_w;
   irs_reg_t rsel_q;
   irs_stat_t snap_q;
   irs_stat_t flags_q;
   irs_stat_t set_w;
   irs_stat_t clr_w;
   irs_stat_t dis_w;
   irs_stat_t raw_w;
   irs_stat_t mask_q;
   irs_abrt_t abrt_src_q;
   logic txe_q;
   logic rd_done_q;
   logic abrt_ack_q;
   logic rx_ack_q;
   logic [`IRS_DATA_W-1:0] rd_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic irs_reg_t reg_decode(input logic [`IRS_ADDR_W-1:0] a);
      irs_reg_t r;
      r = RG_NONE;
      if (a == `IRS_OFS_MASKED) begin
         r = RG_MASKED;
      end else if (a == `IRS_OFS_MASK) begin
         r = RG_MASK;
      end else if (a == `IRS_OFS_RAW) begin
         r = RG_RAW;
      end else if (a == `IRS_OFS_CLR_ALL) begin
         r = RG_CLR_ALL;
      end else if (a == `IRS_OFS_CLR_RDREQ) begin
         r = RG_CLR_RDREQ;
      end else if (a == `IRS_OFS_CLR_ABRT) begin
         r = RG_CLR_ABRT;
      end else if (a == `IRS_OFS_CLR_DONE) begin
         r = RG_CLR_DONE;
      end else if (a == `IRS_OFS_CLR_ACT) begin
         r = RG_CLR_ACT;
      end else if (a == `IRS_OFS_CLR_STOP) begin
         r = RG_CLR_STOP;
      end else if (a == `IRS_OFS_CLR_START) begin
         r = RG_CLR_START;
      end else if (a == `IRS_OFS_CLR_GCALL) begin
         r = RG_CLR_GCALL;
      end else if (a == `IRS_OFS_ABRT_SRC) begin
         r = RG_ABRT_SRC;
      end
      return r;
   endfunction : reg_decode

   // Status bits that a read of the given clear register drops
   function automatic irs_stat_t clr_bits(input irs_reg_t r);
      irs_stat_t m;
      m = '0;
      case (r)
         RG_CLR_ALL: m = `IRS_CLR_ALL_MASK;
         RG_CLR_RDREQ: m[`IRS_B_RDREQ] = 1'h1;
         RG_CLR_ABRT: m[`IRS_B_ABRT] = 1'h1;
         RG_CLR_DONE: m[`IRS_B_DONE] = 1'h1;
         RG_CLR_ACT: m[`IRS_B_ACT] = 1'h1;
         RG_CLR_STOP: m[`IRS_B_STOP] = 1'h1;
         RG_CLR_START: m[`IRS_B_START] = 1'h1;
         RG_CLR_GCALL: m[`IRS_B_GCALL] = 1'h1;
         default: m = '0;
      endcase
      return m;
   endfunction : clr_bits

   ////////////////////////////////////////////////////////////////////////////
   // Link domain front end and crossings

   irs_link_events u_link (
      .link_clk(link_clk),
      .resetn(resetn),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_o(scl_o),
      .scl_oe(scl_oe),
      .gc_ack_evt(gc_ack_evt),
      .slv_nack_evt(slv_nack_evt),
      .abort_evt(abort_evt),
      .abort_reason(abort_reason),
      .rd_req_evt(rd_req_evt),
      .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte),
      .rx_byte_ready(rx_byte_ready),
      .sm_active(sm_active),
      .rd_done_tgl(rd_done_q),
      .abrt_ack(abrt_ack_q),
      .rx_ack(rx_ack_q),
      .ev_tgl(ev_tgl),
      .abrt_tgl(abrt_tgl),
      .abrt_word(abrt_word),
      .rx_tgl(rx_tgl),
      .rx_word(rx_word),
      .act_lvl(act_lvl)
   );

   assign lk_w = {act_lvl, rx_tgl, abrt_tgl, ev_tgl};

   for (genvar gi = 0; gi < MS_COUNT; gi++) begin : g_sync
      logic [`IRS_SYNC_N-1:0] s_q;
      logic f_q;
      always_ff @(posedge clk) begin
         if (!resetn) begin
            s_q <= '0;
            f_q <= 1'h0;
         end else begin
            s_q <= {s_q[`IRS_SYNC_N-2:0], lk_w[gi]};
            if (s_q[`IRS_SYNC_N-2] == s_q[`IRS_SYNC_N-1]) begin
               f_q <= s_q[`IRS_SYNC_N-1];
            end
         end
      end
      assign lf[gi] = f_q;
      assign lc[gi] = (s_q[`IRS_SYNC_N-2] == s_q[`IRS_SYNC_N-1]) && (s_q[`IRS_SYNC_N-1] != f_q);
   end

   // Acks return only after the word is taken, so the link holds it stable
   always_ff @(posedge clk) begin
      if (!resetn) begin
         abrt_ack_q <= 1'h0;
         rx_ack_q <= 1'h0;
      end else begin
         abrt_ack_q <= abrt_ack_q ^ lc[MS_ABRT];
         rx_ack_q <= rx_ack_q ^ lc[MS_RX];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_push <= 1'h0;
         rx_data <= '0;
      end else begin
         rx_push <= lc[MS_RX];
         if (lc[MS_RX]) begin
            rx_data <= rx_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event flags

   always_comb begin
      set_w = '0;
      set_w[`IRS_B_GCALL] = lc[MS_GCALL];
      set_w[`IRS_B_START] = lc[MS_START];
      set_w[`IRS_B_STOP] = lc[MS_STOP];
      set_w[`IRS_B_ACT] = lf[MS_ACT];
      set_w[`IRS_B_DONE] = lc[MS_NACK];
      set_w[`IRS_B_ABRT] = lc[MS_ABRT];
      set_w[`IRS_B_RDREQ] = lc[MS_RDREQ];
   end

   // Only bits seen as 1 when the read was set up are cleared, so nothing is lost
   assign clr_w = rd_acc_w ? (snap_q & clr_bits(rsel_q)) : '0;
   assign dis_w = enable_internal ? '0 : `IRS_DIS_MASK;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= ((flags_q & ~clr_w) | set_w) & ~dis_w;
      end
   end

   // Releases the SCL stretch once software has cleared the request
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_done_q <= 1'h0;
      end else if (clr_w[`IRS_B_RDREQ] && !set_w[`IRS_B_RDREQ]) begin
         rd_done_q <= ~rd_done_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         abrt_src_q <= '0;
      end else if (lc[MS_ABRT]) begin
         abrt_src_q <= abrt_word;
      end else if (clr_w[`IRS_B_ABRT]) begin
         abrt_src_q <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit threshold and FIFO control

   always_ff @(posedge clk) begin
      if (!resetn) begin
         txe_q <= 1'h0;
      end else if (enable_internal) begin
         txe_q <= tx_fifo_level <= {1'h0, tx_threshold};
      end else begin
         txe_q <= lf[MS_ACT];
      end
   end

   assign tx_fifo_flush = !enable_internal || flags_q[`IRS_B_ABRT];
   assign tx_fifo_accept = !tx_fifo_flush;

   always_comb begin
      raw_w = flags_q;
      raw_w[`IRS_B_TXE] = txe_q;
      raw_w[`IRS_LOW_W-1:0] = low_status;
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   assign setup_w = psel && !penable;
   assign rd_acc_w = psel && penable && !pwrite;
   assign dec_w = reg_decode(paddr);
   assign pready = 1'h1;
   assign pslverr = psel && penable && (rsel_q == RG_NONE);

   always_comb begin
      rd_d = '0;
      case (dec_w)
         RG_MASKED: rd_d[`IRS_STAT_W-1:0] = raw_w & mask_q;
         RG_MASK: rd_d[`IRS_STAT_W-1:0] = mask_q;
         RG_RAW: rd_d[`IRS_STAT_W-1:0] = raw_w;
         RG_ABRT_SRC: rd_d[`IRS_ABRT_W-1:0] = abrt_src_q;
         RG_NONE: rd_d = '0;
         default: rd_d[`IRS_CLR_BIT] = |(raw_w & clr_bits(dec_w));
      endcase
   end

   // Read data is registered in the setup phase and stands through access
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rsel_q <= RG_NONE;
         snap_q <= '0;
         prdata <= '0;
      end else if (setup_w) begin
         rsel_q <= dec_w;
         snap_q <= raw_w;
         prdata <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mask_q <= `IRS_MASK_RST;
      end else if (psel && penable && pwrite && rsel_q == RG_MASK) begin
         mask_q <= pwdata[`IRS_STAT_W-1:0];
      end
   end

endmodule : irs_raw_event_status

// ---- dv/irs_raw_event_status_checker.sv ----
/*
 Port checker of the raw event status block.
 Assumes it is bound to irs_raw_event_status and sees only its ports.
*/
`timescale 1ns/1ps
`include "irs_defines.svh"

module irs_raw_event_status_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`IRS_ADDR_W-1:0] paddr,
   input wire logic [`IRS_DATA_W-1:0] prdata,
   input wire logic enable_internal,
   input wire logic [`IRS_LVL_W-1:0] tx_fifo_level,
   input wire logic [`IRS_TL_W-1:0] tx_threshold,
   input wire logic tx_fifo_flush,
   input wire logic tx_fifo_accept,
   input wire logic scl_o,
   input wire logic scl_oe
);
   logic raw_rd;
   logic abrt_clr;
   assign raw_rd = psel && penable && !pwrite && paddr == `IRS_OFS_RAW;
   assign abrt_clr = psel && penable && (paddr == `IRS_OFS_CLR_ABRT || paddr == `IRS_OFS_CLR_ALL);

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////////////
   AST_RSV_ZERO: assert property (raw_rd |-> prdata[31:12] == 20'h0_0000)
      else $error("reserved raw status bits not zero");
   AST_FLUSH_DIS: assert property (!enable_internal |-> tx_fifo_flush)
      else $error("tx fifo not flushed while disabled");
   AST_ACCEPT: assert property (tx_fifo_accept != tx_fifo_flush)
      else $error("tx fifo accepts while flushed");
   // Only the abort clears may end a flush begun by an abort
   AST_ABRT_HOLD: assert property (tx_fifo_flush && enable_internal && !abrt_clr
      |=> tx_fifo_flush || !enable_internal)
      else $error("flush dropped without abort clear");
   AST_ABRT_FLUSH: assert property (raw_rd && prdata[6] |-> $past(tx_fifo_flush))
      else $error("abort flag set without flush");
   // Snapshot at setup holds the bit computed one cycle earlier
   AST_TXE: assert property (raw_rd && $past(resetn, 2) && $past(enable_internal, 2)
      |-> prdata[4] == ($past(tx_fifo_level, 2) <= $past(tx_threshold, 2)))
      else $error("tx threshold bit wrong");
   AST_DIS_CLR: assert property (raw_rd && $past(resetn, 2) && !$past(enable_internal, 2)
      |-> !prdata[11] && !prdata[8])
      else $error("general call or activity survives disable");
   // Stretch starts on the link side before the flag crosses, so a shown request implies it
   AST_SCL_LOW: assert property (raw_rd && prdata[5] |-> scl_oe && !scl_o)
      else $error("read request shown without scl held low");

   cover property (raw_rd && prdata[5]);
   cover property (raw_rd && prdata[6]);
   cover property (raw_rd && prdata[4]);
endmodule : irs_raw_event_status_checker

bind irs_raw_event_status irs_raw_event_status_checker i_chk (.clk, .resetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .enable_internal, .tx_fifo_level, .tx_threshold, .tx_fifo_flush,
   .tx_fifo_accept, .scl_o, .scl_oe);

// ---- dv/irs_bus_model.sv ----
/*
 Remote I2C master on the bus: makes start and stop conditions.
 Assumes pull-ups on SCL and SDA and a running link clock.
*/
`timescale 1ns/1ps

module irs_bus_model (
   input wire logic link_clk,
   input wire logic scl_o,
   input wire logic scl_oe,
   output logic scl_i,
   output logic sda_i
);
   logic scl_rel = 1'b1;
   logic sda_rel = 1'b1;
   // Wired-and with pull-ups: a released line reads high
   assign scl_i = scl_rel & ~(scl_oe & ~scl_o);
   assign sda_i = sda_rel;

   task automatic step(input logic c, input logic d);
      @(negedge link_clk);
      scl_rel = c;
      sda_rel = d;
      // Wait out a stretched clock, bounded
      for (int i = 0; i < 64 && c && !scl_i; i++) @(negedge link_clk);
      repeat (4) @(negedge link_clk);
   endtask : step

   task automatic send_start();
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask : send_start

   task automatic send_stop();
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : send_stop
endmodule : irs_bus_model

// ---- dv/irs_raw_event_status_bench.sv ----
/*
 Self-checking bench of the raw event status block.
 Assumes the design files and the bus model are compiled first.
*/
`timescale 1ns/1ps
`include "irs_defines.svh"

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module irs_raw_event_status_bench;
   logic clk, link_clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic en, flush, accept, rx_push, scl_i, sda_i, scl_o, scl_oe, sm;
   logic rxv, rx_byte_ready;
   logic [5:0] lvl;
   logic [4:0] thr;
   logic [3:0] ev;
   irs_pkg::irs_byte_t rxb, rx_data;
   irs_pkg::irs_abrt_t reason;
   int err_total = 0;
   int n_tests = 0;

   irs_raw_event_status i_dut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enable_internal(en), .tx_fifo_level(lvl),
      .tx_threshold(thr), .low_status(4'h0), .tx_fifo_flush(flush), .tx_fifo_accept(accept),
      .rx_push(rx_push), .rx_data(rx_data), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
      .scl_oe(scl_oe), .gc_ack_evt(ev[0]), .slv_nack_evt(ev[1]), .abort_evt(ev[2]),
      .abort_reason(reason), .rd_req_evt(ev[3]), .rx_byte_valid(rxv), .rx_byte(rxb),
      .rx_byte_ready(rx_byte_ready), .sm_active(sm));

   irs_bus_model i_bus (.link_clk(link_clk), .scl_o(scl_o), .scl_oe(scl_oe), .scl_i(scl_i),
      .sda_i(sda_i));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (err_total == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report

   // One APB transfer: setup, access, answer taken at the closing edge
   task automatic apb(input logic w, input logic [31:0] a, output logic [31:0] r,
      output logic e);
      @(negedge clk);
      psel = 1'b1;
      penable = 1'b0;
      pwrite = w;
      paddr = a;
      @(negedge clk);
      penable = 1'b1;
      @(posedge clk);
      r = prdata;
      e = pslverr;
      @(negedge clk);
      psel = 1'b0;
      penable = 1'b0;
   endtask : apb

   task automatic rd(input logic [31:0] a, input logic [15:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, r, e);
      `CHK(r, {16'h0000, x})
   endtask : rd

   task automatic ev_pulse(input logic [3:0] v);
      @(negedge link_clk);
      ev = v;
      @(negedge link_clk);
      ev = 4'h0;
      repeat (12) @(negedge clk);
   endtask : ev_pulse

   task automatic toggle_en();
      en = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(flush, 1'b1)
      en = 1'b1;
      repeat (4) @(negedge clk);
   endtask : toggle_en

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic e;
      {psel, penable, pwrite, rxv, sm} = 5'h00;
      {paddr, pwdata} = 64'h0000_0000_0000_0000;
      {ev, rxb, reason} = 28'h000_0000;
      en = 1'b1;
      lvl = 6'h0A;
      thr = 5'h04;
      resetn = 1'b0;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge link_clk);
      rd(`IRS_OFS_RAW, 16'h0000);
      rd(`IRS_OFS_MASK, 16'h08FF);
      apb(1'b0, 32'h5000_13F0, r, e);
      `CHK({e, r}, 33'h1_0000_0000)
      i_bus.send_start();
      i_bus.send_stop();
      repeat (12) @(negedge clk);
      apb(1'b0, `IRS_OFS_RAW, r, e);
      `CHK(r[10:9], 2'b11)
      rd(`IRS_OFS_CLR_START, 16'h0001);
      rd(`IRS_OFS_CLR_STOP, 16'h0001);
      for (int m = 0; m < 3; m++) begin
         sm = 1'b1;
         repeat (8) @(negedge clk);
         sm = 1'b0;
         repeat (8) @(negedge clk);
         rd(`IRS_OFS_RAW, 16'h0100);
         if (m == 0) rd(`IRS_OFS_CLR_ACT, 16'h0001);
         else if (m == 1) rd(`IRS_OFS_CLR_ALL, 16'h0001);
         else toggle_en();
         rd(`IRS_OFS_RAW, 16'h0000);
      end
      ev_pulse(4'h1);
      rd(`IRS_OFS_RAW, 16'h0800);
      rd(`IRS_OFS_RAW, 16'h0800);
      rd(`IRS_OFS_CLR_GCALL, 16'h0001);
      ev_pulse(4'h1);
      // Byte after the general call must reach the receive side
      @(negedge link_clk);
      rxv = 1'b1;
      rxb = 8'hA5;
      for (int k = 0; k < 20; k++) begin
         @(posedge link_clk);
         if (rx_byte_ready) break;
      end
      @(negedge link_clk);
      rxv = 1'b0;
      for (int k = 0; k < 40 && rx_push !== 1'b1; k++) @(negedge clk);
      `CHK(rx_push, 1'b1)
      if (rx_push !== 1'b1) final_report();
      `CHK(rx_data, 8'hA5)
      toggle_en();
      rd(`IRS_OFS_RAW, 16'h0000);
      ev_pulse(4'h2);
      rd(`IRS_OFS_RAW, 16'h0080);
      rd(`IRS_OFS_CLR_DONE, 16'h0001);
      reason = 16'h0123;
      ev_pulse(4'h4);
      rd(`IRS_OFS_RAW, 16'h0040);
      rd(`IRS_OFS_ABRT_SRC, 16'h0123);
      `CHK(accept, 1'b0)
      rd(`IRS_OFS_CLR_ABRT, 16'h0001);
      `CHK(accept, 1'b1)
      ev_pulse(4'h8);
      rd(`IRS_OFS_RAW, 16'h0020);
      `CHK({scl_oe, scl_o, scl_i}, 3'b100)
      rd(`IRS_OFS_CLR_RDREQ, 16'h0001);
      rd(`IRS_OFS_RAW, 16'h0000);
      repeat (24) @(negedge clk);
      `CHK(scl_i, 1'b1)
      lvl = 6'h04;
      repeat (3) @(negedge clk);
      rd(`IRS_OFS_RAW, 16'h0010);
      rd(`IRS_OFS_MASKED, 16'h0010);
      pwdata = 32'h0000_0000;
      apb(1'b1, `IRS_OFS_MASK, r, e);
      `CHK({pready, e}, 2'b10)
      rd(`IRS_OFS_MASKED, 16'h0000);
      rd(`IRS_OFS_RAW, 16'h0010);
      lvl = 6'h05;
      repeat (3) @(negedge clk);
      rd(`IRS_OFS_RAW, 16'h0000);
      en = 1'b0;
      sm = 1'b1;
      repeat (8) @(negedge clk);
      rd(`IRS_OFS_RAW, 16'h0010);
      sm = 1'b0;
      repeat (8) @(negedge clk);
      rd(`IRS_OFS_RAW, 16'h0000);
      final_report();
   end

   initial begin
      #2000000;
      err_total++;
      final_report();
   end
endmodule : irs_raw_event_status_bench
